// ---- debug_mux_pkg.sv ----
// Constants and carrier types for the digital debug signal multiplexer
`default_nettype none
package debug_mux_pkg;
   // ==========================================================
   // Register map (APB byte addresses)
   // ==========================================================
   localparam logic [11:0] CFG_OFFSET = 12'h000;    // Group byte and position byte
   localparam logic [11:0] CTRL_OFFSET = 12'h004;   // Probe bus enable
   localparam logic [11:0] STATUS_OFFSET = 12'h008; // Live routing status
   localparam int GROUP_LSB = 0;                    // Group byte position in CFG
   localparam int POS_LSB = 8;                      // Position byte in CFG
   localparam int ENABLE_BIT = 0;                   // Enable bit in CTRL
   localparam int STAT_LEVEL_BIT = 0;               // Routed level in STATUS
   localparam int STAT_ACTIVE_BIT = 1;              // Route active in STATUS
   localparam logic [7:0] GROUP_RESET = 8'h00;      // No group after reset
   localparam logic [7:0] POS_RESET = 8'hff;        // Reserved pin after reset
   localparam logic ENABLE_RESET = 1'b0;
   // ==========================================================
   // Group codes
   // ==========================================================
   localparam logic [7:0] GRP_CLOCK = 8'h01;
   localparam logic [7:0] GRP_TX_ENC = 8'h1b;
   localparam logic [7:0] GRP_TIMER = 8'h1d;
   localparam logic [7:0] GRP_CARD = 8'h30;
   localparam logic [7:0] GRP_TRX = 8'h58;
   localparam logic [7:0] GRP_RX_DATA = 8'h70;
   localparam logic [7:0] GRP_RX_ERR = 8'h73;
   // Usable selectors per group, one bit per selector 0..7
   localparam logic [7:0] MASK_CLOCK = 8'hff;
   localparam logic [7:0] MASK_TX_ENC = 8'h03;
   localparam logic [7:0] MASK_TIMER = 8'hfc;
   localparam logic [7:0] MASK_CARD = 8'hff;
   localparam logic [7:0] MASK_TRX = 8'hff;
   localparam logic [7:0] MASK_RX_DATA = 8'hff;
   localparam logic [7:0] MASK_RX_ERR = 8'hc7;
   // ==========================================================
   // Selector and pin codes
   // ==========================================================
   localparam logic [3:0] SEL_CLK13 = 4'h8;         // Carrier clock in every group
   localparam int PIN_COUNT = 4;
   localparam logic [3:0] PIN_IRQ = 4'h0;           // Interrupt pin
   localparam logic [3:0] PIN_GENERAL_OUTPUT_ONE = 4'h1;
   localparam logic [3:0] PIN_AUXILIARY_TWO = 4'h2;
   localparam logic [3:0] PIN_AUXILIARY_ONE = 4'h3;
   // ==========================================================
   // Carrier of the internal probe sources, indexed by selector
   // ==========================================================
   typedef struct packed {
      logic clk13;           // Carrier clock, 13.56 MHz
      logic [7:0] clockGrp;  // Clock group sources
      logic [7:0] txEncGrp;  // 0 tx interrupt, 1 tx envelope
      logic [7:0] timerGrp;  // 7/5/3 running, 6/4/2 expiry of timers 0/1/2
      logic [7:0] cardGrp;   // Card-mode detection sources
      logic [7:0] trxGrp;    // Transceive sequencing sources
      logic [7:0] rxDataGrp; // Receiver data transfer sources
      logic [7:0] rxErrGrp;  // Receiver error sources
   } debugSrc_t;
endpackage
`default_nettype wire

// ---- digital_debug_signal_mux.sv ----
// Digital debug signal multiplexer with APB configuration registers
`default_nettype none
module digital_debug_signal_mux
   import debug_mux_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Probe sources from other domains
   input wire debugSrc_t debugSrc,
   // Normal functional pin values, same clock
   input wire logic [PIN_COUNT-1:0] normalPins,
   // Pin drive after the multiplexer
   output logic [PIN_COUNT-1:0] debugPins
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      debugSrc_t sync1;              // First synchroniser stage
      debugSrc_t sync2;              // Second synchroniser stage
      logic [7:0] groupSel;          // Group byte
      logic [7:0] posSel;            // Position byte: pin and signal
      logic enable;                  // Probe bus enable
      logic [PIN_COUNT-1:0] pins;    // Registered pin drive
      logic level;                   // Last routed level
      logic active;                  // Last route valid
      logic [31:0] rdata;            // Read data
      logic ready;                   // Access phase answer
      logic err;                     // Error answer
   } muxState_t;

   // Reset: no group, reserved pin, probe bus off
   localparam muxState_t STATE_RESET = '{
      sync1: '0, sync2: '0, groupSel: GROUP_RESET, posSel: POS_RESET,
      enable: ENABLE_RESET, pins: '0, level: 1'b0, active: 1'b0,
      rdata: '0, ready: 1'b0, err: 1'b0};

   muxState_t state; // Current state
   muxState_t next;  // Next state
   logic [7:0] grpBits; // Sources of the chosen group
   logic [7:0] grpMask; // Usable selectors of the chosen group
   logic grpKnown; // Group code decoded
   logic [3:0] sigSel; // Signal selector nibble
   logic [3:0] pinSel; // Pin selector nibble
   logic routeValid; // Route may drive a pin
   logic routeLevel; // Level of the chosen signal
   logic setupPhase; // APB setup cycle
   logic accessDone; // APB transfer completes
   logic addrKnown; // Address is mapped

   // ==========================================================
   // Group decode
   // ==========================================================
   // Returns {known, mask, sources} for a group code
   function automatic logic [16:0] decodeGroup(input logic [7:0] grp, input debugSrc_t src);
      case (grp)
         GRP_CLOCK: decodeGroup = {1'b1, MASK_CLOCK, src.clockGrp};
         GRP_TX_ENC: decodeGroup = {1'b1, MASK_TX_ENC, src.txEncGrp};
         GRP_TIMER: decodeGroup = {1'b1, MASK_TIMER, src.timerGrp};
         GRP_CARD: decodeGroup = {1'b1, MASK_CARD, src.cardGrp};
         GRP_TRX: decodeGroup = {1'b1, MASK_TRX, src.trxGrp};
         GRP_RX_DATA: decodeGroup = {1'b1, MASK_RX_DATA, src.rxDataGrp};
         GRP_RX_ERR: decodeGroup = {1'b1, MASK_RX_ERR, src.rxErrGrp};
         // Unknown codes return zero, so the route is never valid
         default: decodeGroup = '0;
      endcase
   endfunction

   // Address decode of the register map
   function automatic logic isMapped(input logic [11:0] addr);
      isMapped = (addr == CFG_OFFSET) || (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET);
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   // Synchronisers, APB slave and the routing of one source to one pin
   always_comb begin
      next = state;
      // Two-stage synchroniser; stage one feeds stage two only
      next.sync1 = debugSrc;
      next.sync2 = state.sync1;
      // Decode from synchronised sources only
      {grpKnown, grpMask, grpBits} = decodeGroup(state.groupSel, state.sync2);
      sigSel = state.posSel[POS_LSB-5:0];
      pinSel = state.posSel[7:4];
      // Selector 8 is usable in every known group
      routeLevel = (sigSel == SEL_CLK13) ? state.sync2.clk13 : grpBits[sigSel[2:0]];
      // Reserved group, selector or pin codes keep every pin functional
      routeValid = state.enable && grpKnown && (pinSel < 4'(PIN_COUNT))
         && ((sigSel == SEL_CLK13) || (!sigSel[3] && grpMask[sigSel[2:0]]));
      // Chosen pin carries the probe, the others stay functional
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (routeValid && (pinSel == 4'(i))) begin
            next.pins[i] = routeLevel;
         end else begin
            next.pins[i] = normalPins[i];
         end
      end
      next.level = routeValid && routeLevel;
      next.active = routeValid;
      // APB: answer in the first access cycle
      setupPhase = psel && !penable;
      accessDone = psel && penable && state.ready;
      addrKnown = isMapped(paddr);
      // Registered answer: zero wait states, pready rises in the first access cycle
      next.ready = setupPhase;
      if (setupPhase) begin
         // Error on unmapped address or write to status
         next.err = !addrKnown || (pwrite && (paddr == STATUS_OFFSET));
         next.rdata = '0;
         if (!pwrite) begin
            case (paddr)
               CFG_OFFSET: next.rdata = {16'h0000, state.posSel, state.groupSel};
               CTRL_OFFSET: next.rdata[ENABLE_BIT] = state.enable;
               STATUS_OFFSET: begin
                  next.rdata[STAT_LEVEL_BIT] = state.level;
                  next.rdata[STAT_ACTIVE_BIT] = state.active;
               end
               default: next.rdata = '0;
            endcase
         end
      end else if (!accessDone) begin
         next.err = state.err;
      end else begin
         next.err = 1'b0;
      end
      // Writes take effect at the completing edge
      // A cleared strobe lane leaves that byte as it was
      if (accessDone && pwrite) begin
         if (paddr == CFG_OFFSET) begin
            if (pstrb[0]) begin
               next.groupSel = pwdata[GROUP_LSB +: 8];
            end
            if (pstrb[1]) begin
               next.posSel = pwdata[POS_LSB +: 8];
            end
         end else if (paddr == CTRL_OFFSET && pstrb[0]) begin
            next.enable = pwdata[ENABLE_BIT];
         end
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   // Synchronous reset, clock enable freezes everything
   // Reset wins over a low clock enable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= STATE_RESET;
      end else if (ce) begin
         state <= next;
      end
   end

   // Outputs straight from flip-flops
   // Raw sources would glitch the pins; only the pin register drives them
   assign prdata = state.rdata;
   assign pready = state.ready;
   assign pslverr = state.err;
   assign debugPins = state.pins;

   // ==========================================================
   // Assertions
   // ==========================================================
   // All checks sample on the rising edge and pause in reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Config byte write lands in both fields
   cfg_write_a: assert property (ce && psel && penable && pready && pwrite
      && paddr == CFG_OFFSET && pstrb[1:0] == 2'b11
      |=> state.groupSel == $past(pwdata[7:0]) && state.posSel == $past(pwdata[15:8]))
      else $error("config write not stored");

   // Carrier clock reaches the chosen pin
   clk_route_a: assert property (ce && state.enable && grpKnown && sigSel == SEL_CLK13
      && pinSel < 4'(PIN_COUNT) |=> debugPins[$past(pinSel[1:0])] == $past(state.sync2.clk13))
      else $error("carrier clock not routed");

   // Only the chosen pin leaves its normal value
   other_pins_a: assert property (ce && routeValid
      |=> ((debugPins ^ $past(normalPins)) & ~(4'h1 << $past(pinSel[1:0]))) == 4'h0)
      else $error("unselected pin disturbed");

   // Unknown group code drives no probe
   bad_group_a: assert property (ce && !grpKnown |=> debugPins == $past(normalPins))
      else $error("unknown group drove a pin");

   // Clock group selector 6 shows pll lock on the interrupt pin
   clock_sel_a: assert property (ce && state.enable && state.groupSel == GRP_CLOCK
      && state.posSel == 8'h06 |=> debugPins[0] == $past(state.sync2.clockGrp[6]))
      else $error("clock group selector wrong");

   // Timer zero running flag on general output one
   timer_sel_a: assert property (ce && state.enable && state.groupSel == GRP_TIMER
      && state.posSel == 8'h17 |=> debugPins[1] == $past(state.sync2.timerGrp[7]))
      else $error("timer selector wrong");

   // Reserved timer selector leaves pins functional
   timer_rsvd_a: assert property (ce && state.groupSel == GRP_TIMER && sigSel == 4'h1
      |=> debugPins == $past(normalPins))
      else $error("reserved timer selector drove a pin");

   // Receiver error reserved selectors drive nothing
   rxerr_rsvd_a: assert property (ce && state.groupSel == GRP_RX_ERR
      && sigSel inside {4'h3, 4'h4, 4'h5} |=> debugPins == $past(normalPins))
      else $error("reserved error selector drove a pin");

   // Reserved pin codes drive nothing
   pin_rsvd_a: assert property (ce && pinSel >= 4'(PIN_COUNT)
      |=> debugPins == $past(normalPins))
      else $error("reserved pin code drove a pin");

   // Disabled probe bus never drives a probe
   bus_off_a: assert property ((ce && !state.enable) [*2] |=> debugPins == $past(normalPins))
      else $error("probe drove pin while disabled");

   // Reserved signal selectors drive nothing
   sig_rsvd_a: assert property (ce && sigSel > SEL_CLK13
      |=> debugPins == $past(normalPins))
      else $error("reserved selector drove a pin");

   // Answer one cycle after setup
   apb_ready_a: assert property (ce && psel && !penable ##1 ce && psel && penable |-> pready)
      else $error("access phase not answered");

   // Card-mode clock-fail flag on auxiliary pin two
   card_sel_a: assert property (ce && state.enable && state.groupSel == GRP_CARD
      && state.posSel == 8'h27 |=> debugPins[2] == $past(state.sync2.cardGrp[7]))
      else $error("card-mode selector wrong");

   // Waiting-time flag on auxiliary pin one
   trx_sel_a: assert property (ce && state.enable && state.groupSel == GRP_TRX
      && state.posSel == 8'h33 |=> debugPins[3] == $past(state.sync2.trxGrp[3]))
      else $error("transceive selector wrong");

   // Receiver data-valid on the interrupt pin
   rxdata_sel_a: assert property (ce && state.enable && state.groupSel == GRP_RX_DATA
      && state.posSel == 8'h05 |=> debugPins[0] == $past(state.sync2.rxDataGrp[5]))
      else $error("receiver data selector wrong");

   // Length overrun flag on general output one
   rxerr_sel_a: assert property (ce && state.enable && state.groupSel == GRP_RX_ERR
      && state.posSel == 8'h16 |=> debugPins[1] == $past(state.sync2.rxErrGrp[6]))
      else $error("receiver error selector wrong");

   // Reserved encoder selectors drive nothing
   txenc_rsvd_a: assert property (ce && state.groupSel == GRP_TX_ENC
      && sigSel inside {[4'h2:4'h7]} |=> debugPins == $past(normalPins))
      else $error("reserved encoder selector drove a pin");

   // Enable bit reads back as stored
   ctrl_read_a: assert property (ce && psel && !penable && !pwrite
      && paddr == CTRL_OFFSET |=> prdata == {31'h0, $past(state.enable)})
      else $error("probe enable read back wrong");

   // Unmapped address answers with an error
   slverr_a: assert property (ce && psel && !penable && !isMapped(paddr)
      |=> pready && pslverr)
      else $error("unmapped access not refused");

   // Low clock enable freezes all state
   freeze_a: assert property (!ce |=> $stable(state))
      else $error("state moved while clock enable low");

   // Main scenarios
   carrier_cover: cover property (ce && routeValid && sigSel == SEL_CLK13);
   rxdata_cover: cover property (ce && routeValid && state.groupSel == GRP_RX_DATA);
   aux_one_cover: cover property (ce && routeValid && pinSel == PIN_AUXILIARY_ONE);
   slverr_cover: cover property (pready && pslverr);
   freeze_cover: cover property (!ce ##1 ce);
endmodule // digital_debug_signal_mux
`default_nettype wire

// ---- apb_host.sv ----
// Host controller model that issues configuration transfers over APB
`default_nettype none
module apb_host
   import debug_mux_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Request from the bench, held until done
   input wire logic req,
   input wire logic wr,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] strb,
   output logic done,
   output logic [31:0] rdata,
   output logic err,
   // APB master side
   output logic [11:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ==========================================================
   // Transfer sequencer
   // ==========================================================
   // Setup, then access held until pready; released address and data lines show inverted values
   always @(posedge clk) begin
      done <= 1'b0;
      if (sys_rst) begin
         psel <= 1'b0;
         penable <= 1'b0;
      end else if (!psel && req && !done) begin
         // Both command bytes travel in one word
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= wdata;
         pstrb <= strb;
      end else if (psel && !penable) begin
         penable <= 1'b1;
      end else if (psel && penable && pready) begin
         // Answer taken at the same edge as pready
         rdata <= prdata;
         err <= pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         paddr <= ~paddr;
         pwdata <= ~pwdata;
         done <= 1'b1;
      end
   end
endmodule // apb_host
`default_nettype wire

// ---- digital_debug_signal_mux_bench.sv ----
// Self-checking bench for the digital debug signal multiplexer
`default_nettype none
module digital_debug_signal_mux_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import debug_mux_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clk = 1'b0;
   logic sysRst = 1'b1;
   logic ce = 1'b1;
   logic req = 1'b0, wr = 1'b0, done, err, psel, penable, pwrite, pready, pslverr;
   logic [11:0] addr = 12'h000, paddr;
   logic [31:0] wdata = 32'h0, rdata, pwdata, prdata;
   logic [3:0] strb = 4'h0, pstrb, debugPins;
   logic [3:0] normalPins = 4'h5; // Functional pin values
   debugSrc_t src = 57'h1a5_c396_f0e1_d2b3; // Probe source pattern
   int n_mismatch = 0;
   int checked = 0;
   always #10 clk = ~clk;
   digital_debug_signal_mux dut (.clk(clk), .sys_rst(sysRst), .ce(ce), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .debugSrc(src),
      .normalPins(normalPins), .debugPins(debugPins));
   apb_host host (.clk(clk), .sys_rst(sysRst), .req(req), .wr(wr), .addr(addr),
      .wdata(wdata), .strb(strb), .done(done), .rdata(rdata), .err(err), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task summarize;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Compare one value
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer through the host model
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      req <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      strb <= s;
      // Wait for done from the host; the watchdog ends a hung wait
      while (done !== 1'b1) @(posedge clk);
      req <= 1'b0;
   endtask
   // Expected pin drive for a group, position byte and enable
   function automatic logic [3:0] expPins(input logic [7:0] g, input logic [7:0] pos,
      input debugSrc_t v, input logic en);
      logic [7:0] vec, msk;
      logic [3:0] p;
      p = normalPins;
      case (g)
         GRP_CLOCK: begin vec = v.clockGrp; msk = MASK_CLOCK; end
         GRP_TX_ENC: begin vec = v.txEncGrp; msk = MASK_TX_ENC; end
         GRP_TIMER: begin vec = v.timerGrp; msk = MASK_TIMER; end
         GRP_CARD: begin vec = v.cardGrp; msk = MASK_CARD; end
         GRP_TRX: begin vec = v.trxGrp; msk = MASK_TRX; end
         GRP_RX_DATA: begin vec = v.rxDataGrp; msk = MASK_RX_DATA; end
         GRP_RX_ERR: begin vec = v.rxErrGrp; msk = MASK_RX_ERR; end
         default: begin vec = 8'h00; msk = 8'h00; end
      endcase
      if (en && pos[7:4] < 4'h4 && msk != 8'h00) begin
         if (pos[3:0] == SEL_CLK13)
            p[pos[5:4]] = v.clk13;
         else if (pos[3:0] < 4'h8 && msk[pos[2:0]])
            p[pos[5:4]] = vec[pos[2:0]];
      end
      return p;
   endfunction
   // ==========================================================
   // Scenarios
   // ==========================================================
   task testReset;
      chk({28'h0, debugPins}, {28'h0, normalPins});
      apb(1'b0, CFG_OFFSET, 32'h0, 4'h0);
      chk(rdata, 32'h0000ff00);
      apb(1'b0, CTRL_OFFSET, 32'h0, 4'h0);
      chk(rdata, 32'h0);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, STATUS_OFFSET, 32'h3, 4'hf);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
   endtask
   task testDisabled;
      apb(1'b1, CFG_OFFSET, 32'h0000_0501, 4'hf);
      repeat (5) @(posedge clk);
      chk({28'h0, debugPins}, {28'h0, normalPins});
      $display("disabled test done");
   endtask
   task testStrobe;
      apb(1'b1, CTRL_OFFSET, 32'h1, 4'hf);
      apb(1'b1, CFG_OFFSET, 32'h0000_7870, 4'h2);
      apb(1'b0, CFG_OFFSET, 32'h0, 4'h0);
      chk(rdata, 32'h0000_7801);
      repeat (5) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0, 4'h0);
      chk({31'h0, rdata[STAT_ACTIVE_BIT]}, 32'h0);
      apb(1'b1, CFG_OFFSET, 32'h0000_3800, 4'h2);
      repeat (5) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0, 4'h0);
      chk({30'h0, rdata[1:0]}, {30'h0, 1'b1, src.clk13});
      chk({31'h0, debugPins[3]}, {31'h0, src.clk13});
      $display("strobe test done");
   endtask
   task testRoutes;
      logic [7:0] grps [9];
      logic [7:0] pos;
      int gi, si;
      grps = '{8'h01, 8'h1b, 8'h1d, 8'h30, 8'h58, 8'h70, 8'h73, 8'h00, 8'h10};
      for (gi = 0; gi < 9; gi++) begin
         for (si = 0; si < 10; si++) begin
            pos = {4'(si % 5), 4'(si)};
            apb(1'b1, CFG_OFFSET, {16'h0, pos, grps[gi]}, 4'hf);
            repeat (5) @(posedge clk);
            chk(debugPins, expPins(grps[gi], pos, src, 1'b1));
            src <= ~src;
            normalPins <= ~normalPins;
            repeat (5) @(posedge clk);
            chk(debugPins, expPins(grps[gi], pos, src, 1'b1));
         end
      end
      $display("route test done");
   endtask
   task testFreeze;
      logic [3:0] held;
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      held = debugPins;
      normalPins <= ~normalPins;
      repeat (5) @(posedge clk);
      chk({28'h0, debugPins}, {28'h0, held});
      ce <= 1'b1;
      repeat (5) @(posedge clk);
      chk({28'h0, debugPins}, {28'h0, normalPins});
      $display("freeze test done");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      repeat (10) @(posedge clk);
      sysRst <= 1'b0;
      // Pins leave their reset value one edge after release
      repeat (3) @(posedge clk);
      testReset;
      testDisabled;
      testStrobe;
      testRoutes;
      testFreeze;
      summarize;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize;
   end
endmodule // digital_debug_signal_mux_bench
`default_nettype wire
